/* File: core/event_capture_asymmetric_pulse_output_regs.vh */
// constants for the event capture and asymmetric pwm channel
`ifndef EVENT_CAPTURE_ASYMMETRIC_PULSE_OUTPUT_REGS_VH
`define EVENT_CAPTURE_ASYMMETRIC_PULSE_OUTPUT_REGS_VH

// data widths
`define TS_WIDTH            32
`define SLOT_INDEX_WIDTH    2

// slot indices in the shared timestamp array
`define SLOT_FIRST          2'h0
`define SLOT_SECOND         2'h1
`define SLOT_THIRD          2'h2
`define SLOT_FOURTH         2'h3

// sticky event flag positions
`define FLAG_WIDTH          7
`define FLAG_CAPTURE_FIRST  0
`define FLAG_CAPTURE_SECOND 1
`define FLAG_CAPTURE_THIRD  2
`define FLAG_CAPTURE_FOURTH 3
`define FLAG_COUNTER_WRAP   4
`define FLAG_PERIOD_MATCH   5
`define FLAG_COMPARE_MATCH  6

// reset values
`define TS_RESET            32'h00000000
`define FLAGS_RESET         7'h00

// alignment output pulse width in clock cycles
`define ALIGN_OUT_CYCLES    4'h8
`define ALIGN_CNT_WIDTH     4

// least input hold time the source must give, in clock cycles
`define CAPTURE_MIN_HOLD_CYCLES 2

`endif

/* File: core/capture_edge_detect.v */
// two-flop synchroniser with rising edge detection for an external pin
`default_nettype none

module capture_edge_detect
(
  input  wire ref_clk,
  input  wire sys_rst,
  input  wire pin_in,
  output wire level,
  output wire rise_pulse
);

  reg sync_first;
  reg sync_second;
  reg level_prev;

  // first stage feeds only the second stage
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sync_first  <= 1'b0;
      sync_second <= 1'b0;
      level_prev  <= 1'b0;
    end
    else
    begin
      sync_first  <= pin_in;
      sync_second <= sync_first;
      level_prev  <= sync_second;
    end
  end

  // edge found between two settled samples
  assign level      = sync_second;
  assign rise_pulse = sync_second & ~level_prev;

endmodule // capture_edge_detect

`default_nettype wire

/* File: core/event_capture_asymmetric_pulse_output.v */
// one capture channel with asymmetric pwm secondary function
//
// Overview of operation
// - capture_or_pwm_select high picks pwm generation, low picks input capture.
// - in pwm generation the counter only counts upward as the time base.
// - first slot is active period, second slot is active compare in pwm.
// - third slot shadows the period, fourth slot shadows the compare in pwm.
// - one array of four timestamp slots serves both capture and pwm.
// - counter loads from an alignment input and drives an alignment output.
// - capture, pwm and counter events set flags driving one interrupt line.
// - all logic runs on one clock; a control bit gates the counter, captures, matches and shadow writes.
`default_nettype none
`include "event_capture_asymmetric_pulse_output_regs.vh"

module event_capture_asymmetric_pulse_output
(
  input  wire                    ref_clk,
  input  wire                    sys_rst,
  input  wire                    module_clock_on,
  input  wire                    capture_or_pwm_select,
  input  wire                    capture_in,
  input  wire                    timebase_align_in,
  input  wire                    align_load_enable,
  input  wire [`TS_WIDTH-1:0]    align_phase,
  input  wire                    shadow_period_wr,
  input  wire                    shadow_compare_wr,
  input  wire [`TS_WIDTH-1:0]    shadow_data,
  input  wire [`FLAG_WIDTH-1:0]  flag_clear,
  output wire [`TS_WIDTH-1:0]    timestamp_slot_first,
  output wire [`TS_WIDTH-1:0]    timestamp_slot_second,
  output wire [`TS_WIDTH-1:0]    timestamp_slot_third,
  output wire [`TS_WIDTH-1:0]    timestamp_slot_fourth,
  output reg  [`TS_WIDTH-1:0]    counter_value,
  output reg                     asymmetric_pulse_output,
  output wire                    timebase_align_out,
  output reg  [`FLAG_WIDTH-1:0]  event_flags,
  output wire                    channel_event_irq
);

  // shared slot storage
  reg [`TS_WIDTH-1:0]        slot [0:3];
  reg [`SLOT_INDEX_WIDTH-1:0] capture_ptr;
  reg [`ALIGN_CNT_WIDTH-1:0]  align_out_count;

  wire                     capture_rise;
  wire                     align_rise;
  wire                     pwm_mode;
  wire                     run;
  wire                     period_hit;
  wire                     compare_hit;
  wire                     counter_wrap;
  wire                     capture_event;
  wire                     align_load;
  reg  [`FLAG_WIDTH-1:0]   flag_set;
  reg  [`TS_WIDTH-1:0]     next_counter;
  wire [`FLAG_WIDTH-1:0]   next_event_flags;

  // capture pin crosses into the clock domain before use
  capture_edge_detect capture_sync
  (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .pin_in     (capture_in),
    .level      (),
    .rise_pulse (capture_rise)
  );

  // alignment input from neighbouring channels
  capture_edge_detect align_sync
  (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .pin_in     (timebase_align_in),
    .level      (),
    .rise_pulse (align_rise)
  );

  // mode and clock gate decode
  assign pwm_mode      = capture_or_pwm_select;
  assign run           = module_clock_on;
  assign align_load    = run & align_load_enable & align_rise;
  assign period_hit    = run & pwm_mode & (counter_value == slot[`SLOT_FIRST]);
  assign compare_hit   = run & pwm_mode & (counter_value == slot[`SLOT_SECOND]);
  assign counter_wrap  = run & ~pwm_mode & (counter_value == {`TS_WIDTH{1'b1}});
  // a capture edge only counts while the channel clock is on and capture mode is selected
  assign capture_event = run & ~pwm_mode & capture_rise;

  // next counter value: always counts upward, restarts at period in pwm
  always @*
  begin
    next_counter = counter_value;
    if (align_load)
    begin
      next_counter = align_phase;
    end
    else if (period_hit)
    begin
      next_counter = `TS_RESET;
    end
    else if (run)
    begin
      next_counter = counter_value + 32'h00000001;
    end
  end

  // time base counter, holds while the channel clock is gated off
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      counter_value <= `TS_RESET;
    end
    else
    begin
      counter_value <= next_counter;
    end
  end

  // shared slots: timestamps in capture, period/compare and shadows in pwm
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      slot[`SLOT_FIRST]  <= `TS_RESET;
      slot[`SLOT_SECOND] <= `TS_RESET;
      slot[`SLOT_THIRD]  <= `TS_RESET;
      slot[`SLOT_FOURTH] <= `TS_RESET;
      capture_ptr        <= `SLOT_FIRST;
    end
    else if (!pwm_mode)
    begin
      if (capture_event)
      begin
        slot[capture_ptr] <= counter_value;
        capture_ptr       <= capture_ptr + 2'h1;             // wraps after fourth
      end
    end
    else
    begin
      capture_ptr <= `SLOT_FIRST;
      if (period_hit)
      begin
        slot[`SLOT_FIRST]  <= slot[`SLOT_THIRD];
        slot[`SLOT_SECOND] <= slot[`SLOT_FOURTH];
      end
      // shadow writes land after any copy in the same cycle took the old value
      if (run && shadow_period_wr)
      begin
        slot[`SLOT_THIRD] <= shadow_data;
      end
      if (run && shadow_compare_wr)
      begin
        slot[`SLOT_FOURTH] <= shadow_data;
      end
    end
  end

  // slot outputs are the shared array itself
  assign timestamp_slot_first  = slot[`SLOT_FIRST];
  assign timestamp_slot_second = slot[`SLOT_SECOND];
  assign timestamp_slot_third  = slot[`SLOT_THIRD];
  assign timestamp_slot_fourth = slot[`SLOT_FOURTH];

  // pwm output: high on restart, low on compare, low in capture mode
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      asymmetric_pulse_output <= 1'b0;
    end
    else if (!pwm_mode)
    begin
      asymmetric_pulse_output <= 1'b0;
    end
    else if (period_hit)
    begin
      asymmetric_pulse_output <= 1'b1;
    end
    else if (compare_hit)
    begin
      asymmetric_pulse_output <= 1'b0;
    end
  end

  // alignment output stretched over a fixed number of cycles on each restart
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      align_out_count <= {`ALIGN_CNT_WIDTH{1'b0}};
    end
    else if (period_hit || counter_wrap)
    begin
      align_out_count <= `ALIGN_OUT_CYCLES;
    end
    else if (align_out_count != {`ALIGN_CNT_WIDTH{1'b0}})
    begin
      align_out_count <= align_out_count - 4'h1;
    end
  end

  assign timebase_align_out = (align_out_count != {`ALIGN_CNT_WIDTH{1'b0}});

  // event sources for the sticky flags
  always @*
  begin
    flag_set = `FLAGS_RESET;
    flag_set[`FLAG_CAPTURE_FIRST]  = capture_event & (capture_ptr == `SLOT_FIRST);
    flag_set[`FLAG_CAPTURE_SECOND] = capture_event & (capture_ptr == `SLOT_SECOND);
    flag_set[`FLAG_CAPTURE_THIRD]  = capture_event & (capture_ptr == `SLOT_THIRD);
    flag_set[`FLAG_CAPTURE_FOURTH] = capture_event & (capture_ptr == `SLOT_FOURTH);
    flag_set[`FLAG_COUNTER_WRAP]   = counter_wrap;
    flag_set[`FLAG_PERIOD_MATCH]   = period_hit;
    flag_set[`FLAG_COMPARE_MATCH]  = compare_hit;
  end

  // next sticky flag per bit, a new event beats a clear in the same cycle
  genvar fi;
  generate
    for (fi = 0; fi < `FLAG_WIDTH; fi = fi + 1)
    begin : g_flag
      assign next_event_flags[fi] = flag_set[fi] | (event_flags[fi] & ~flag_clear[fi]);
    end
  endgenerate

  // one register for all flags, so the vector has a single driver
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      event_flags <= `FLAGS_RESET;
    end
    else
    begin
      event_flags <= next_event_flags;
    end
  end

  // single interrupt line toward the interrupt expander
  assign channel_event_irq = |event_flags;

endmodule // event_capture_asymmetric_pulse_output

`default_nettype wire

/* File: verif/event_capture_asymmetric_pulse_output_props.sv */
// concurrent checks on the capture and pwm channel ports
`default_nettype none
`include "event_capture_asymmetric_pulse_output_regs.vh"
module event_capture_asymmetric_pulse_output_props
(
  input wire logic                   ref_clk,
  input wire logic                   sys_rst,
  input wire logic                   module_clock_on,
  input wire logic                   capture_or_pwm_select,
  input wire logic                   align_load_enable,
  input wire logic [`TS_WIDTH-1:0]   timestamp_slot_first,
  input wire logic [`TS_WIDTH-1:0]   timestamp_slot_second,
  input wire logic [`TS_WIDTH-1:0]   timestamp_slot_third,
  input wire logic [`TS_WIDTH-1:0]   timestamp_slot_fourth,
  input wire logic [`TS_WIDTH-1:0]   counter_value,
  input wire logic                   asymmetric_pulse_output,
  input wire logic                   timebase_align_out,
  input wire logic [`FLAG_WIDTH-1:0] event_flags,
  input wire logic                   channel_event_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // pwm running with no alignment load allowed, and the period match
  wire run_pwm = module_clock_on & capture_or_pwm_select & ~align_load_enable;
  wire at_per = counter_value == timestamp_slot_first;
  property p_mode; !capture_or_pwm_select [*2] |-> !asymmetric_pulse_output; endproperty
  a_mode: assert property (p_mode) else $error("pwm output in capture mode");
  property p_up; run_pwm && !at_per |=> counter_value == $past(counter_value) + 1; endproperty
  a_up: assert property (p_up) else $error("count not upward");
  property p_restart; run_pwm && at_per |=> counter_value == 0 && asymmetric_pulse_output; endproperty
  a_restart: assert property (p_restart) else $error("no restart at period");
  property p_compare; run_pwm && !at_per && counter_value == timestamp_slot_second |=> !asymmetric_pulse_output;
  endproperty
  a_compare: assert property (p_compare) else $error("output high past compare");
  property p_shadow; run_pwm && at_per |=> timestamp_slot_first == $past(timestamp_slot_third) &&
    timestamp_slot_second == $past(timestamp_slot_fourth); endproperty
  a_shadow: assert property (p_shadow) else $error("shadow copy missing");
  property p_align; run_pwm && at_per |=> timebase_align_out [*8]; endproperty
  a_align: assert property (p_align) else $error("alignment pulse short");
  property p_gate; !module_clock_on |=> $stable(counter_value) && $stable(timestamp_slot_first); endproperty
  a_gate: assert property (p_gate) else $error("gated channel moved");
  property p_capture; !capture_or_pwm_select && $rose(event_flags[0]) |->
    timestamp_slot_first == $past(counter_value) && channel_event_irq; endproperty
  a_capture: assert property (p_capture) else $error("bad capture");
endmodule // event_capture_asymmetric_pulse_output_props
bind event_capture_asymmetric_pulse_output event_capture_asymmetric_pulse_output_props i_props (.*);
`default_nettype wire

/* File: verif/event_source_model.sv */
// external event source: each request gives a pin level held three cycles
`default_nettype none
module event_source_model
(
  input  wire logic ref_clk,
  input  wire logic fire_capture,
  input  wire logic fire_align,
  output wire logic capture_in,
  output wire logic timebase_align_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cap_hist = 3'h0;
  logic [2:0] aln_hist = 3'h0;
  // request history keeps each level up three cycles, above the two-cycle floor
  always @(posedge ref_clk)
  begin
    cap_hist <= {cap_hist[1:0], fire_capture};
    aln_hist <= {aln_hist[1:0], fire_align};
  end
  assign capture_in = |cap_hist;
  assign timebase_align_in = |aln_hist;
endmodule // event_source_model
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the capture and pwm channel
`default_nettype none
`include "event_capture_asymmetric_pulse_output_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'h0, sys_rst = 1'h1, module_clock_on = 1'h0, capture_or_pwm_select = 1'h0;
  logic align_load_enable = 1'h0, shadow_period_wr = 1'h0, shadow_compare_wr = 1'h0;
  logic fire_capture = 1'h0, fire_align = 1'h0, capture_in, timebase_align_in;
  logic [`TS_WIDTH-1:0] align_phase = 32'h0, shadow_data = 32'h0, counter_value;
  logic [`TS_WIDTH-1:0] timestamp_slot_first, timestamp_slot_second, timestamp_slot_third;
  logic [`TS_WIDTH-1:0] timestamp_slot_fourth;
  logic [`FLAG_WIDTH-1:0] flag_clear = 7'h00, event_flags;
  logic asymmetric_pulse_output, timebase_align_out, channel_event_irq;
  int num_errors = 0;
  int n_checks = 0;
  event_capture_asymmetric_pulse_output i_dut (.*);
  event_source_model i_src (.*);
  // free-running clock
  always #20 ref_clk = ~ref_clk;
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // one-cycle request: 0 capture pin, 1 alignment pin, 2 shadow period write, 3 shadow compare write
  task automatic pulse(input int which);
    case (which)
      0: fire_capture = 1'h1;
      1: fire_align = 1'h1;
      2: shadow_period_wr = 1'h1;
      default: shadow_compare_wr = 1'h1;
    endcase
    cyc(1);
    case (which)
      0: fire_capture = 1'h0;
      1: fire_align = 1'h0;
      2: shadow_period_wr = 1'h0;
      default: shadow_compare_wr = 1'h0;
    endcase
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // four captures ten cycles apart fill every slot in turn
  task automatic t_capture();
    module_clock_on = 1'h1;
    repeat (4)
    begin
      pulse(0);
      cyc(9);
    end
    chk("flags", event_flags, 32'hF);
    chk("irq", channel_event_irq, 32'h1);
    chk("gap", timestamp_slot_second - timestamp_slot_first, 32'hA);
    chk("gap", timestamp_slot_fourth - timestamp_slot_third, 32'hA);
    flag_clear = 7'h7F;
    cyc(1);
    flag_clear = 7'h00;
    cyc(1);
    chk("irq", channel_event_irq, 32'h0);
  endtask
  // period nine and compare three go in through the shadows after an alignment
  task automatic t_pwm();
    int hi;
    int al;
    capture_or_pwm_select = 1'h1;
    shadow_data = 32'h9;
    pulse(2);
    shadow_data = 32'h3;
    pulse(3);
    chk("shadow", timestamp_slot_third, 32'h9);
    align_load_enable = 1'h1;
    pulse(1);
    cyc(5);
    align_load_enable = 1'h0;
    chk("align", counter_value < 32'h8, 32'h1);
    for (int i = 0; i < 40 && timestamp_slot_first !== 32'h9; i++)
      cyc(1);
    for (int i = 0; i < 40 && counter_value !== 32'h9; i++)
      cyc(1);
    cyc(1);
    hi = 0;
    al = 0;
    repeat (10)
    begin
      hi += asymmetric_pulse_output;
      al += timebase_align_out;
      cyc(1);
    end
    chk("period", timestamp_slot_first, 32'h9);
    chk("compare", timestamp_slot_second, 32'h3);
    chk("high", hi, 32'h4);
    chk("align out", al, 32'h8);
    pulse(0);
    cyc(5);
    chk("no capture", event_flags[3:0], 32'h0);
    chk("pwm flags", event_flags[6:4], 32'h6);
  endtask
  // back to capture mode, then gating freezes the count
  task automatic t_stop();
    logic [31:0] held;
    for (int i = 0; i < 20 && counter_value !== 32'h8; i++)
      cyc(1);
    capture_or_pwm_select = 1'h0;
    cyc(2);
    chk("pwm off", asymmetric_pulse_output, 32'h0);
    module_clock_on = 1'h0;
    cyc(1);
    held = counter_value;
    cyc(5);
    chk("frozen", counter_value, held);
    module_clock_on = 1'h1;
  endtask
  // capture mode: alignment loads near the top, the count wraps, flags it and drives the alignment output
  task automatic t_wrap();
    flag_clear = 7'h7F;
    cyc(1);
    flag_clear = 7'h00;
    align_phase = 32'hFFFFFFF0;
    align_load_enable = 1'h1;
    pulse(1);
    cyc(5);
    align_load_enable = 1'h0;
    chk("aligned", counter_value[31:4], 32'h0FFFFFFF);
    cyc(16);
    chk("wrap flag", event_flags, 32'h10);
    chk("wrap align out", timebase_align_out, 32'h1);
    chk("wrapped", counter_value < 32'h10, 32'h1);
  endtask
  // main sequence
  initial
  begin
    cyc(2);
    sys_rst = 1'h0;
    t_capture();
    t_pwm();
    t_stop();
    t_wrap();
    finish_test();
  end
  // watchdog at 2000 cycles, far beyond the roughly 113 cycles the run needs
  initial
  begin
    #80000;
    num_errors++;
    finish_test();
  end
endmodule // testbench
`default_nettype wire
